// *** rtl/cca_pkg.sv ***
// constants, offsets and types shared by the compare/convert/divide datapath
package cca_pkg;
    // apb register byte offsets
    localparam logic [7:0]  CCA_OFS_CTRL      = 8'h00;
    localparam logic [7:0]  CCA_OFS_OPSEL     = 8'h04;
    localparam logic [7:0]  CCA_OFS_LOOP      = 8'h08;
    localparam logic [7:0]  CCA_OFS_STATUS    = 8'h0C;
    localparam logic [7:0]  CCA_OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  CCA_OFS_IRQ_MASK  = 8'h14;
    localparam logic [1:0]  CCA_RF_REGION     = 2'h1;
    // control register fields
    localparam int unsigned CCA_CTRL_IDLE_CLR = 0;
    localparam int unsigned CCA_CTRL_WIDE     = 1;
    localparam int unsigned CCA_CTRL_PULSE    = 2;
    localparam logic [2:0]  CCA_CTRL_RST      = 3'h0;
    // operand select fields, four bits each
    localparam int unsigned CCA_SEL_A         = 0;
    localparam int unsigned CCA_SEL_B         = 4;
    localparam int unsigned CCA_SEL_D         = 8;
    localparam logic [11:0] CCA_OPSEL_RST     = 12'h000;
    // control input lanes from the scan sequencer
    localparam int unsigned CCA_OP_CMP        = 0;
    localparam int unsigned CCA_OP_OR         = 1;
    localparam int unsigned CCA_OP_TOBCD      = 2;
    localparam int unsigned CCA_OP_TOBIN      = 3;
    localparam int unsigned CCA_OP_BREAK      = 4;
    localparam int unsigned CCA_OP_DIV        = 5;
    localparam int unsigned CCA_OP_N          = 6;
    // interrupt status and mask bits
    localparam int unsigned CCA_IRQ_CMP       = 0;
    localparam int unsigned CCA_IRQ_CONV_ERR  = 1;
    localparam int unsigned CCA_IRQ_DIV_DONE  = 2;
    localparam int unsigned CCA_IRQ_DIV_ERR   = 3;
    localparam int unsigned CCA_IRQ_LOOP_END  = 4;
    localparam int unsigned CCA_IRQ_N         = 5;
    localparam logic [4:0]  CCA_IRQ_RST       = 5'h00;
    // conversion limits
    localparam logic [15:0] CCA_BCD_LIM16     = 16'd9999;
    localparam logic [31:0] CCA_BCD_LIM32     = 32'd9999999;
    // divider
    localparam int unsigned CCA_DIV_W         = 48;
    localparam logic [5:0]  CCA_DIV_LAST      = 6'd47;
    // operand register file
    localparam int unsigned CCA_RF_DEPTH      = 16;
    typedef logic [CCA_RF_DEPTH-1:0][15:0] cca_rf_t;
    typedef enum logic {CCA_DIV_IDLE, CCA_DIV_RUN} cca_div_state_t;
endpackage : cca_pkg

// *** rtl/cca_alu_if.sv ***
// signals between the datapath top and its converter and divider units
`timescale 1ns/100ps
interface cca_alu_if;
    logic [31:0] conv_src;
    logic        conv_wide;
    logic [31:0] bcd_val;
    logic        bcd_err;
    logic [31:0] bin_val;
    logic        bin_err;
    logic        div_go;
    logic [47:0] div_dividend;
    logic [47:0] div_divisor;
    logic        div_busy;
    logic        div_done;
    logic        div_zero_div;
    logic [47:0] div_quot;
    modport conv_user (output conv_src, conv_wide, input bcd_val, bcd_err, bin_val, bin_err);
    modport conv_unit (input conv_src, conv_wide, output bcd_val, bcd_err, bin_val, bin_err);
    modport div_user  (output div_go, div_dividend, div_divisor,
                       input div_busy, div_done, div_zero_div, div_quot);
    modport div_unit  (input div_go, div_dividend, div_divisor,
                       output div_busy, div_done, div_zero_div, div_quot);
endinterface : cca_alu_if

// *** rtl/cca_conv.sv ***
// binary to packed decimal and packed decimal to binary converters
`timescale 1ns/100ps
module cca_conv (
    // converter side of the shared interface
    cca_alu_if.conv_unit cv
);
    import cca_pkg::*;

    // shift-and-add-three over all 32 source bits
    function automatic logic [31:0] cca_to_bcd(input logic [31:0] v);
        logic [63:0] s;
        s = {32'h0000_0000, v};
        for (int i = 0; i < 32; i++) begin
            for (int j = 0; j < 8; j++) begin
                if (s[32+4*j +: 4] >= 4'h5) begin
                    s[32+4*j +: 4] = s[32+4*j +: 4] + 4'h3;
                end
            end
            s = s << 1;
        end
        return s[63:32];
    endfunction : cca_to_bcd

    logic [31:0] acc;
    logic        bad;

    always_comb begin
        // out of range leaves the destination alone, flagged as error
        cv.bcd_val = cca_to_bcd(cv.conv_wide ? cv.conv_src : {16'h0000, cv.conv_src[15:0]});
        cv.bcd_err = cv.conv_wide ? (cv.conv_src > CCA_BCD_LIM32)
                                  : (cv.conv_src[15:0] > CCA_BCD_LIM16);
        acc = 32'h0000_0000;
        bad = 1'b0;
        for (int k = 7; k >= 0; k--) begin
            if (cv.conv_wide || k < 4) begin
                if (cv.conv_src[4*k +: 4] > 4'h9) begin
                    bad = 1'b1;
                end
                acc = acc * 32'd10 + {28'h0, cv.conv_src[4*k +: 4]};
            end
        end
        cv.bin_val = acc;
        cv.bin_err = bad;
    end
endmodule : cca_conv

// *** rtl/cca_div48.sv ***
// 48-bit unsigned restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module cca_div48 (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // divider side of the shared interface
    cca_alu_if.div_unit      dv
);
    import cca_pkg::*;

    typedef struct packed {
        cca_div_state_t st;
        logic [5:0]     cnt;
        logic [48:0]    rem;
        logic [47:0]    quo;
        logic [47:0]    dsr;
        logic [47:0]    res;
        logic           done;
        logic           dz;
    } cca_div_reg_t;

    cca_div_reg_t r_q;
    cca_div_reg_t r_d;
    logic [48:0]  sh;

    always_comb begin
        r_d      = r_q;
        r_d.done = 1'b0;
        sh       = {r_q.rem[47:0], r_q.quo[47]};
        case (r_q.st)
            CCA_DIV_IDLE: begin
                if (dv.div_go) begin
                    if (dv.div_divisor == 48'h0000_0000_0000) begin
                        r_d.done = 1'b1;
                        r_d.dz   = 1'b1;
                    end else begin
                        r_d.dz  = 1'b0;
                        r_d.st  = CCA_DIV_RUN;
                        r_d.cnt = 6'd0;
                        r_d.rem = 49'h0;
                        r_d.quo = dv.div_dividend;
                        r_d.dsr = dv.div_divisor;
                    end
                end
            end
            CCA_DIV_RUN: begin
                r_d.quo = {r_q.quo[46:0], 1'b0};
                if (sh >= {1'b0, r_q.dsr}) begin
                    r_d.rem    = sh - {1'b0, r_q.dsr};
                    r_d.quo[0] = 1'b1;
                end else begin
                    r_d.rem = sh;
                end
                r_d.cnt = r_q.cnt + 6'd1;
                if (r_q.cnt == CCA_DIV_LAST) begin
                    r_d.st   = CCA_DIV_IDLE;
                    r_d.done = 1'b1;
                    r_d.res  = r_d.quo;
                end
            end
            default: r_d.st = CCA_DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign dv.div_busy     = (r_q.st == CCA_DIV_RUN);
    assign dv.div_done     = r_q.done;
    assign dv.div_zero_div = r_q.dz;
    assign dv.div_quot     = r_q.res;
endmodule : cca_div48

// *** rtl/cca_alu.sv ***
// compare, or, code conversion, loop break and 48-bit divide datapath with apb registers
`timescale 1ns/100ps
module cca_alu (
    // clock and reset
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_in,
    // apb slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [7:0]                 paddr_in,
    input  wire logic [31:0]                pwdata_in,
    output logic      [31:0]                prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    // scan sequencer
    input  wire logic                       scan_in,
    input  wire logic                       loop_next_in,
    input  wire logic [cca_pkg::CCA_OP_N-1:0] ctl_in,
    // results
    output logic                            result_flag_first_out,
    output logic                            result_flag_second_out,
    output logic                            result_flag_third_out,
    output logic                            conv_err_out,
    output logic                            div_zero_out,
    output logic                            div_err_out,
    output logic                            loop_active_out,
    output logic                            loop_exit_out,
    output logic                            irq_out
);
    import cca_pkg::*;

    typedef struct packed {
        logic [2:0]          ctrl;
        logic [11:0]         opsel;
        logic [15:0]         loop_left;
        logic                loop_active;
        logic                loop_exit;
        cca_rf_t             rf;
        logic [CCA_OP_N-1:0] ctl_prev;
        logic                flag_first;
        logic                flag_second;
        logic                flag_third;
        logic                conv_err;
        logic                div_zero;
        logic                div_err;
        logic [3:0]          div_dst;
        logic [4:0]          irq_stat;
        logic [4:0]          irq_mask;
        logic                irq;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } cca_top_reg_t;

    cca_top_reg_t r_q;
    cca_top_reg_t r_d;
    cca_alu_if    alu_if ();

    // reads one word, or two consecutive words in wide mode, low word first
    function automatic logic [31:0] cca_rd(input cca_rf_t rf, input logic [3:0] idx,
                                           input logic wide);
        logic [3:0] nx;
        nx = idx + 4'h1;
        return wide ? {rf[nx], rf[idx]} : {{16{rf[idx][15]}}, rf[idx]};
    endfunction : cca_rd

    // three consecutive words form one 48-bit operand
    function automatic logic [47:0] cca_rd48(input cca_rf_t rf, input logic [3:0] idx);
        logic [3:0] i1;
        logic [3:0] i2;
        i1 = idx + 4'h1;
        i2 = idx + 4'h2;
        return {rf[i2], rf[i1], rf[idx]};
    endfunction : cca_rd48

    logic [3:0]          sel_a;
    logic [3:0]          sel_b;
    logic [3:0]          sel_d;
    logic [3:0]          sel_d1;
    logic                wide;
    logic [31:0]         op_a;
    logic [31:0]         op_b;
    logic [CCA_OP_N-1:0] trig;
    logic [CCA_OP_N-1:0] run;
    logic                apb_acc;
    logic                apb_end;
    logic                in_rf;
    logic [3:0]          rf_idx;
    logic [4:0]          ev;
    logic [4:0]          w1c;
    logic [31:0]         rdv;
    logic                map_ok;
    logic [31:0]         or_res;

    assign sel_a  = r_q.opsel[CCA_SEL_A +: 4];
    assign sel_b  = r_q.opsel[CCA_SEL_B +: 4];
    assign sel_d  = r_q.opsel[CCA_SEL_D +: 4];
    assign sel_d1 = sel_d + 4'h1;
    assign wide   = r_q.ctrl[CCA_CTRL_WIDE];
    assign op_a   = cca_rd(r_q.rf, sel_a, wide);
    assign op_b   = cca_rd(r_q.rf, sel_b, wide);
    assign or_res = op_a | op_b;

    // pulse variant sees only a low-to-high change between two scans
    assign trig = r_q.ctrl[CCA_CTRL_PULSE] ? (ctl_in & ~r_q.ctl_prev) : ctl_in;
    assign run  = scan_in ? trig : '0;

    assign alu_if.conv_src     = op_a;
    assign alu_if.conv_wide    = wide;
    // a divide asked for while one is running is dropped, not queued
    assign alu_if.div_go       = run[CCA_OP_DIV] & ~alu_if.div_busy;
    assign alu_if.div_dividend = cca_rd48(r_q.rf, sel_a);
    assign alu_if.div_divisor  = cca_rd48(r_q.rf, sel_b);

    cca_conv u_conv (
        .cv (alu_if)
    );

    cca_div48 u_div (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .dv         (alu_if)
    );

    // apb decode: access phase answered on its second cycle
    assign apb_acc = psel_in & penable_in;
    assign apb_end = apb_acc & r_q.pready;
    assign in_rf   = (paddr_in[7:6] == CCA_RF_REGION);
    assign rf_idx  = paddr_in[5:2];

    always_comb begin
        map_ok = 1'b1;
        rdv    = 32'h0000_0000;
        if (in_rf) begin
            rdv = {16'h0000, r_q.rf[rf_idx]};
        end else if (paddr_in == CCA_OFS_CTRL) begin
            rdv = {29'h0, r_q.ctrl};
        end else if (paddr_in == CCA_OFS_OPSEL) begin
            rdv = {20'h0, r_q.opsel};
        end else if (paddr_in == CCA_OFS_LOOP) begin
            rdv = {16'h0000, r_q.loop_left};
        end else if (paddr_in == CCA_OFS_STATUS) begin
            rdv = {24'h0, alu_if.div_busy, r_q.loop_active, r_q.div_err, r_q.div_zero,
                   r_q.conv_err, r_q.flag_third, r_q.flag_second, r_q.flag_first};
        end else if (paddr_in == CCA_OFS_IRQ_STAT) begin
            rdv = {27'h0, r_q.irq_stat};
        end else if (paddr_in == CCA_OFS_IRQ_MASK) begin
            rdv = {27'h0, r_q.irq_mask};
        end else begin
            map_ok = 1'b0;
        end
    end

    always_comb begin
        r_d           = r_q;
        ev            = '0;
        w1c           = '0;
        r_d.loop_exit = 1'b0;
        r_d.pready    = apb_acc & ~r_q.pready;
        r_d.pslverr   = apb_acc & ~r_q.pready & ~map_ok;
        if (apb_acc && !r_q.pready && !pwrite_in) begin
            r_d.prdata = rdv;
        end
        // software writes land first so that same-cycle results win
        if (apb_end && pwrite_in) begin
            if (in_rf) begin
                r_d.rf[rf_idx] = pwdata_in[15:0];
            end else if (paddr_in == CCA_OFS_CTRL) begin
                r_d.ctrl = pwdata_in[2:0];
            end else if (paddr_in == CCA_OFS_OPSEL) begin
                r_d.opsel = pwdata_in[11:0];
            end else if (paddr_in == CCA_OFS_LOOP) begin
                r_d.loop_left   = pwdata_in[15:0];
                r_d.loop_active = (pwdata_in[15:0] != 16'h0000);
            end else if (paddr_in == CCA_OFS_IRQ_STAT) begin
                w1c = pwdata_in[4:0];
            end else if (paddr_in == CCA_OFS_IRQ_MASK) begin
                r_d.irq_mask = pwdata_in[4:0];
            end
        end
        if (scan_in) begin
            r_d.ctl_prev = ctl_in;
        end
        if (run[CCA_OP_CMP]) begin
            r_d.flag_first  = (op_a == op_b);
            r_d.flag_second = ($signed(op_a) > $signed(op_b));
            r_d.flag_third  = ($signed(op_a) < $signed(op_b));
            ev[CCA_IRQ_CMP] = 1'b1;
        end else if (scan_in && r_q.ctrl[CCA_CTRL_IDLE_CLR]) begin
            r_d.flag_first  = 1'b0;
            r_d.flag_second = 1'b0;
            r_d.flag_third  = 1'b0;
        end
        if (run[CCA_OP_OR]) begin
            r_d.rf[sel_d] = or_res[15:0];
            if (wide) begin
                r_d.rf[sel_d1] = or_res[31:16];
            end
        end
        if (run[CCA_OP_TOBCD]) begin
            r_d.conv_err = alu_if.bcd_err;
            if (!alu_if.bcd_err) begin
                r_d.rf[sel_d] = alu_if.bcd_val[15:0];
                if (wide) begin
                    r_d.rf[sel_d1] = alu_if.bcd_val[31:16];
                end
            end
        end
        if (run[CCA_OP_TOBIN]) begin
            r_d.conv_err = alu_if.bin_err;
            if (!alu_if.bin_err) begin
                r_d.rf[sel_d] = alu_if.bin_val[15:0];
                if (wide) begin
                    r_d.rf[sel_d1] = alu_if.bin_val[31:16];
                end
            end
        end
        if ((run[CCA_OP_TOBCD] && alu_if.bcd_err) || (run[CCA_OP_TOBIN] && alu_if.bin_err)) begin
            ev[CCA_IRQ_CONV_ERR] = 1'b1;
        end
        if (alu_if.div_go) begin
            r_d.div_dst = sel_d;
        end
        if (alu_if.div_done) begin
            if (alu_if.div_zero_div) begin
                r_d.div_err         = 1'b1;
                ev[CCA_IRQ_DIV_ERR] = 1'b1;
            end else begin
                r_d.div_err                 = 1'b0;
                r_d.div_zero                = (alu_if.div_quot == 48'h0000_0000_0000);
                r_d.rf[r_q.div_dst]         = alu_if.div_quot[15:0];
                r_d.rf[r_q.div_dst + 4'h1]  = alu_if.div_quot[31:16];
                r_d.rf[r_q.div_dst + 4'h2]  = alu_if.div_quot[47:32];
                ev[CCA_IRQ_DIV_DONE]        = 1'b1;
            end
        end
        if (r_q.loop_active) begin
            if (run[CCA_OP_BREAK]) begin
                r_d.loop_active       = 1'b0;
                r_d.loop_left         = 16'h0000;
                r_d.loop_exit         = 1'b1;
                ev[CCA_IRQ_LOOP_END]  = 1'b1;
            end else if (loop_next_in) begin
                r_d.loop_left = r_q.loop_left - 16'h0001;
                if (r_q.loop_left == 16'h0001) begin
                    r_d.loop_active      = 1'b0;
                    r_d.loop_exit        = 1'b1;
                    ev[CCA_IRQ_LOOP_END] = 1'b1;
                end
            end
        end
        // a new event wins over a clear written in the same cycle
        r_d.irq_stat = (r_q.irq_stat & ~w1c) | ev;
        r_d.irq      = |(r_d.irq_stat & r_d.irq_mask);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r_q          <= '0;
            r_q.ctrl     <= CCA_CTRL_RST;
            r_q.opsel    <= CCA_OPSEL_RST;
            r_q.irq_stat <= CCA_IRQ_RST;
            r_q.irq_mask <= CCA_IRQ_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata_out             = r_q.prdata;
    assign pready_out             = r_q.pready;
    assign pslverr_out            = r_q.pslverr;
    assign result_flag_first_out  = r_q.flag_first;
    assign result_flag_second_out = r_q.flag_second;
    assign result_flag_third_out  = r_q.flag_third;
    assign conv_err_out           = r_q.conv_err;
    assign div_zero_out           = r_q.div_zero;
    assign div_err_out            = r_q.div_err;
    assign loop_active_out        = r_q.loop_active;
    assign loop_exit_out          = r_q.loop_exit;
    assign irq_out                = r_q.irq;
endmodule : cca_alu

// *** test/cca_alu_monitor.sv ***
// port checks for the datapath top
`timescale 1ns/100ps
module cca_alu_monitor (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // apb and sequencer
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic scan_in,
    // results
    input wire logic result_flag_first_out,
    input wire logic result_flag_second_out,
    input wire logic result_flag_third_out,
    input wire logic conv_err_out,
    input wire logic loop_active_out,
    input wire logic loop_exit_out
);
    wire logic [2:0] flags = {result_flag_first_out, result_flag_second_out, result_flag_third_out};
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence setup_s; psel_in && !penable_in; endsequence
    sequence wait_s; psel_in && penable_in && !pready_out; endsequence
    ready_wait_a: assert property (setup_s ##1 wait_s |=> pready_out)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("slave error without ready");
    flags_onehot_a: assert property ($onehot0(flags))
        else $error("several compare flags");
    flags_hold_a: assert property (!scan_in |=> $stable(flags))
        else $error("flags moved outside a scan");
    conv_hold_a: assert property (!scan_in |=> $stable(conv_err_out))
        else $error("conversion error moved outside a scan");
    exit_pulse_a: assert property (loop_exit_out |=> !loop_exit_out)
        else $error("loop exit longer than one cycle");
    exit_ends_a: assert property (loop_exit_out |-> !loop_active_out && $past(loop_active_out))
        else $error("loop exit without active loop ending");
endmodule : cca_alu_monitor
bind cca_alu cca_alu_monitor i_mon (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pready_out,
    .pslverr_out, .scan_in, .result_flag_first_out, .result_flag_second_out,
    .result_flag_third_out, .conv_err_out, .loop_active_out, .loop_exit_out);

// *** test/cca_seq_model.sv ***
// scan sequencer model: scan pulses with op controls, loop end pulses
`timescale 1ns/100ps
module cca_seq_model (
    // clock
    input  wire logic                         clk_sys_in,
    // sequencer side
    output logic                              scan_out,
    output logic                              loop_next_out,
    output logic [cca_pkg::CCA_OP_N-1:0]      ctl_out
);
    import cca_pkg::*;
    initial begin
        scan_out = 1'b0;
        loop_next_out = 1'b0;
        ctl_out = '0;
    end
    // controls stay at their level between scans, as rung inputs do
    task automatic scan(input logic [CCA_OP_N-1:0] ops, input int gap);
        repeat (gap + 1) @(posedge clk_sys_in);
        scan_out <= 1'b1;
        ctl_out <= ops;
        @(posedge clk_sys_in);
        scan_out <= 1'b0;
    endtask : scan
    task automatic next();
        @(posedge clk_sys_in);
        loop_next_out <= 1'b1;
        @(posedge clk_sys_in);
        loop_next_out <= 1'b0;
    endtask : next
endmodule : cca_seq_model

// *** test/tb.sv ***
// self-checking bench: apb tasks and scan sequences
`timescale 1ns/100ps
module tb;
    import cca_pkg::*;
    logic clk_sys_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
    logic scan_in, loop_next_in, irq_out, conv_err_out, div_zero_out, div_err_out;
    logic result_flag_first_out, result_flag_second_out, result_flag_third_out;
    logic loop_active_out, loop_exit_out;
    logic [7:0]          paddr_in;
    logic [31:0]         pwdata_in, prdata_out, rd;
    logic [CCA_OP_N-1:0] ctl_in;
    int                  fail_count, checked;
    logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    // ctrl, operand a, operand b, flags first/second/third
    logic [39:0] cmp [4] = '{40'h0_0005_0003_2, 40'h0_0003_0003_4, 40'h0_FFFF_0001_1,
                             40'h2_8000_0001_2};
    // op lane, source, destination, error
    logic [39:0] cnv [5] = '{40'h2_04D2_1234_0, 40'h2_2710_1234_1, 40'h3_0567_0237_0,
                             40'h3_00A1_0237_1, 40'h1_00F0_00F1_1};
    cca_alu i_dut (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .scan_in, .loop_next_in, .ctl_in,
        .result_flag_first_out, .result_flag_second_out, .result_flag_third_out,
        .conv_err_out, .div_zero_out, .div_err_out, .loop_active_out, .loop_exit_out, .irq_out);
    cca_seq_model i_seq (.clk_sys_in, .scan_out(scan_in), .loop_next_out(loop_next_in),
        .ctl_out(ctl_in));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // ready and read data are taken at the rising edge that samples them
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1 && ++n < 20);
        if (pready_out !== 1'b1) fail_count++;
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("register", exp, rd);
    endtask : rchk
    task automatic sc(input logic [CCA_OP_N-1:0] ops);
        i_seq.scan(ops, 0);
        @(negedge clk_sys_in);
    endtask : sc
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // run needs a few hundred cycles
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        rst_in = 1'b1;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (ofs[i]) rchk(ofs[i], 32'h0);
        rchk(8'h20, 32'h0);
        chk("slave error", 32'h1, 32'(er));
        apb(1'b1, CCA_OFS_IRQ_MASK, 32'h1);
        apb(1'b1, CCA_OFS_OPSEL, 32'h420);
        foreach (cmp[i]) begin
            apb(1'b1, CCA_OFS_CTRL, 32'(cmp[i][39:36]));
            apb(1'b1, 8'h40, 32'(cmp[i][35:20]));
            apb(1'b1, 8'h48, 32'(cmp[i][19:4]));
            sc(6'h01);
            chk("flags", 32'(cmp[i][3:0]), 32'({result_flag_first_out, result_flag_second_out,
                result_flag_third_out}));
        end
        chk("irq", 32'h1, 32'(irq_out));
        apb(1'b1, CCA_OFS_IRQ_STAT, 32'h1F);
        repeat (2) @(negedge clk_sys_in);
        chk("irq", 32'h0, 32'(irq_out));
        apb(1'b1, CCA_OFS_CTRL, 32'h1);
        sc(6'h00);
        chk("flags", 32'h0, 32'(result_flag_second_out));
        apb(1'b1, CCA_OFS_CTRL, 32'h0);
        apb(1'b1, 8'h40, 32'h8000);
        sc(6'h01);
        sc(6'h00);
        chk("less", 32'h1, 32'(result_flag_third_out));
        apb(1'b1, CCA_OFS_CTRL, 32'h5);
        sc(6'h00);
        sc(6'h01);
        chk("less", 32'h1, 32'(result_flag_third_out));
        sc(6'h01);
        chk("less", 32'h0, 32'(result_flag_third_out));
        apb(1'b1, CCA_OFS_CTRL, 32'h0);
        foreach (cnv[i]) begin
            apb(1'b1, 8'h40, 32'(cnv[i][35:20]));
            sc(6'(1) << cnv[i][39:36]);
            rchk(8'h50, 32'(cnv[i][19:4]));
            chk("conversion error", 32'(cnv[i][3:0]), 32'(conv_err_out));
        end
        apb(1'b1, CCA_OFS_CTRL, 32'h2);
        apb(1'b1, 8'h44, 32'h8000);
        sc(6'h02);
        rchk(8'h54, 32'h8000);
        apb(1'b1, CCA_OFS_CTRL, 32'h0);
        apb(1'b1, CCA_OFS_OPSEL, 32'h630);
        foreach (ofs[i]) apb(1'b1, 8'h40 + 8'(4 * i), 32'(i == 0 ? 100 : i == 2 ? 1 : i == 3 ? 7 : 0));
        sc(6'h20);
        repeat (55) @(negedge clk_sys_in);
        rchk(8'h58, 32'h4932);
        rchk(8'h5C, 32'h2492);
        apb(1'b1, 8'h4C, 32'h0);
        sc(6'h20);
        repeat (5) @(negedge clk_sys_in);
        chk("divide error", 32'h1, 32'(div_err_out));
        rchk(8'h58, 32'h4932);
        apb(1'b1, 8'h4C, 32'h7);
        apb(1'b1, 8'h48, 32'h0);
        apb(1'b1, 8'h40, 32'h5);
        sc(6'h20);
        repeat (55) @(negedge clk_sys_in);
        chk("zero quotient", 32'h1, 32'(div_zero_out));
        rchk(8'h58, 32'h0);
        apb(1'b1, CCA_OFS_LOOP, 32'h3);
        i_seq.next();
        sc(6'h10);
        chk("loop active", 32'h0, 32'(loop_active_out));
        apb(1'b1, CCA_OFS_LOOP, 32'h2);
        i_seq.next();
        rchk(CCA_OFS_LOOP, 32'h1);
        i_seq.next();
        repeat (2) @(negedge clk_sys_in);
        chk("loop active", 32'h0, 32'(loop_active_out));
        end_of_test();
    end
endmodule : tb
